// ==== bench/nand_model.sv ====
`timescale 1ns/10ps
// behavioural flash part on the far side of the pins
module nand_model (
	// strobes from host
	input wire logic cmd_latch,
	input wire logic addr_latch,
	input wire logic chip_sel_n,
	input wire logic write_strobe_n,
	input wire logic output_strobe_n,
	input wire logic [7:0] io_out,
	// answers to host
	output logic [7:0] io_in,
	output logic ready_busy
);
	int fetch_ns = 200; // slowed by one test
	int fail_block = -1; // block whose status fails
	int viol = 0; // host misbehaviour count
	int last_block = -1; // last addressed block
	int gen = 0; // busy episode id
	int col, blk, pg, acnt;
	logic [7:0] cmd_r, dbyte;
	logic [7:0] ab [4];
	logic spare_r, stat_r, fail_r, rd_r;
	logic [7:0] mem [int]; // main byte 0 per page
	int pcnt [int]; // pages programmed since erase
	realtime hi_t;

	// markers: page 0 of block 3, page 1 of block 7
	// a mark touches only its own block
	function automatic logic bad_mark(int b, int p);
		return (b == 3 && p == 0) || (b == 7 && p == 1);
	endfunction

	task automatic go_busy(input int ns);
		int id;
		begin
		gen++;
		id = gen;
		#50 ready_busy = 1'b0;
		#(ns) if (id == gen) ready_busy = 1'b1;
		end
	endtask

	task automatic prog_end();
		int k;
		begin
		k = blk * 32 + pg;
		if (pcnt.exists(k)) viol++;
		pcnt[k] = 1;
		mem[k] = dbyte;
		fail_r = (blk == fail_block);
		fork go_busy(2000); join_none
		end
	endtask

	task automatic erase_end();
		begin
		if (bad_mark(blk, 0) || bad_mark(blk, 1)) viol++;
		for (int p = 0; p < 32; p++) begin
			mem.delete(blk * 32 + p);
			pcnt.delete(blk * 32 + p);
		end
		fail_r = (blk == fail_block);
		fork go_busy(5000); join_none
		end
	endtask

	function automatic logic [7:0] out_byte();
		int k;
		k = blk * 32 + pg;
		if (stat_r) return {1'b1, ready_busy, 5'h00, fail_r};
		if (ready_busy !== 1'b1) return 8'h00;
		if (spare_r) return (col == 5 && bad_mark(blk, pg)) ? 8'h00 : 8'hff;
		return (col == 0 && mem.exists(k)) ? mem[k] : 8'hff;
	endfunction

	initial begin
		ready_busy = 1'b1;
		io_in = 8'h5a;
		{spare_r, stat_r, fail_r, rd_r} = 4'h0;
		hi_t = 0;
	end

	// latch command, address or data on strobe rise
	always @(posedge write_strobe_n) begin
		if (!chip_sel_n && cmd_latch) begin
			cmd_r = io_out;
			acnt = 0;
			stat_r = (io_out == 8'h70);
			case (io_out)
			8'h00: spare_r = 1'b0;
			8'h50: spare_r = 1'b1;
			8'h10: prog_end();
			8'hd0: erase_end();
			8'hff: fork go_busy(1000); join_none
			default: ;
			endcase
		end else if (!chip_sel_n && addr_latch) begin
			ab[acnt] = io_out;
			acnt++;
			col = ab[0];
			pg = ab[1][4:0];
			blk = {ab[3][0], ab[2], ab[1][7:5]};
			if (cmd_r == 8'h60) blk = {ab[2][0], ab[1], ab[0][7:5]};
			last_block = blk;
			// page fetch after last address byte
			if (acnt == 4 && cmd_r != 8'h80) begin
				fork go_busy(fetch_ns); join_none
			end
		end else if (!chip_sel_n) begin
			if (!spare_r && col == 0) dbyte = io_out;
			col++;
		end
	end

	// data shows some time after strobe falls
	always @(negedge output_strobe_n) begin
		#25 io_in = out_byte();
	end

	// page end starts next fetch; bus decays after hold
	always @(posedge output_strobe_n) begin
		// ignore the settling edge at time zero while unselected
		rd_r = !stat_r && chip_sel_n === 1'b0;
		if (rd_r) col++;
		if (rd_r && col > (spare_r ? 15 : 511)) begin
			col = 0;
			pg++;
			fork go_busy(fetch_ns); join_none
		end
		#15 io_in = ~io_in;
	end

	// intercepted read is ready after 50ns
	always @(posedge chip_sel_n) begin
		hi_t = $realtime;
		if (rd_r && ready_busy === 1'b0) begin
			gen++;
			#50 ready_busy = 1'b1;
		end
	end

	// select must stay high 100ns after a read
	always @(negedge chip_sel_n) begin
		if (rd_r && $realtime - hi_t < 100.0) viol++;
		rd_r = 1'b0;
	end
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/10ps
`define check_eq(g, e) begin n_checks++; if ((g) !== (e)) begin \
	err_total++; \
	$display("BAD t=%0t got %0h exp %0h", $time, g, e); end end
// self-checking bench for the flash host
module tb
	import flash_host_pkg::*;
;
	logic clk, reset;
	// request side
	logic req_valid, req_ready, rsp_valid, rsp_fail, scan_done;
	logic [1:0] req_op;
	logic [BLK_W-1:0] req_block;
	logic [4:0] req_page;
	logic [7:0] req_data, rsp_data, io_out, io_in;
	// flash pins
	logic cmd_latch, addr_latch, chip_sel_n, write_strobe_n;
	logic output_strobe_n, write_prot_n, io_oe_n, ready_busy;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;

	// a 16-block scan still covers the marked blocks 3 and 7
	flash_host #(.SCAN_LAST(12'h00f)) uut (.clk, .reset, .req_valid,
		.req_op, .req_block,
		.req_page, .req_data, .req_ready, .rsp_data, .rsp_valid,
		.rsp_fail, .scan_done, .cmd_latch, .addr_latch, .chip_sel_n,
		.write_strobe_n, .output_strobe_n, .write_prot_n, .io_out,
		.io_oe_n, .io_in, .ready_busy);
	nand_model model (.cmd_latch, .addr_latch, .chip_sel_n,
		.write_strobe_n, .output_strobe_n, .io_out, .io_in, .ready_busy);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ceiling well above the shortened scan and all tests
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			$display("BAD t=%0t run too long", $time);
			finish_test();
		end
	end

	task finish_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// offer one request, hold it until taken, wait for the answer
	task automatic req(input logic [1:0] op, input logic [11:0] b,
		input logic [4:0] p, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge clk);
		req_valid = 1'b1;
		req_op = op;
		req_block = b;
		req_page = p;
		req_data = d;
		while (req_ready !== 1'b1 && n < 1000) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		req_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 50000) begin
			@(negedge clk);
			n++;
		end
		`check_eq(rsp_valid, 1'b1)
	endtask

	task t_scan();
		int n;
		n = 0;
		while (scan_done !== 1'b1 && n < 40000) begin
			@(negedge clk);
			n++;
		end
		`check_eq(scan_done, 1'b1)
		`check_eq(model.viol, 0)
		$display("test scan done");
	endtask

	task t_basic();
		req(REQ_READ, 12'h000, 5'h00, 8'h00);
		`check_eq(rsp_data, 8'hff)
		`check_eq(model.last_block, 0)
		`check_eq(chip_sel_n, 1'b1)
		`check_eq(io_oe_n, 1'b1)
		`check_eq(write_prot_n, 1'b1)
		req(REQ_PROG, 12'h001, 5'h02, 8'ha5);
		`check_eq(rsp_fail, 1'b0)
		req(REQ_READ, 12'h001, 5'h02, 8'h00);
		`check_eq(rsp_data, 8'ha5)
		req(REQ_PROG, 12'h001, 5'h02, 8'h3c);
		`check_eq(rsp_fail, 1'b1)
		req(REQ_ERASE, 12'h001, 5'h00, 8'h00);
		`check_eq(rsp_fail, 1'b0)
		req(REQ_PROG, 12'h001, 5'h02, 8'h3c);
		`check_eq(rsp_fail, 1'b0)
		req(REQ_READ, 12'h001, 5'h02, 8'h00);
		`check_eq(rsp_data, 8'h3c)
		$display("test program erase done");
	endtask

	task t_remap();
		req(REQ_READ, 12'h003, 5'h00, 8'h00);
		`check_eq(model.last_block, 4)
		req(REQ_READ, 12'h007, 5'h00, 8'h00);
		`check_eq(model.last_block, 8)
		$display("test remap done");
	endtask

	task t_fail();
		model.fail_block = 10;
		req(REQ_PROG, 12'h00a, 5'h00, 8'h11);
		`check_eq(rsp_fail, 1'b1)
		model.fail_block = -1;
		req(REQ_PROG, 12'h00a, 5'h01, 8'h22);
		`check_eq(rsp_fail, 1'b0)
		`check_eq(model.last_block == 10, 1'b0)
		$display("test retire done");
	endtask

	task t_misc();
		req(REQ_RESET, 12'h000, 5'h00, 8'h00);
		`check_eq(rsp_fail, 1'b0)
		model.fetch_ns = 11000;
		req(REQ_READ, 12'h001, 5'h02, 8'h00);
		`check_eq(rsp_fail, 1'b0)
		`check_eq(rsp_data, 8'h3c)
		model.fetch_ns = 200;
		`check_eq(model.viol, 0)
		$display("test reset slow fetch done");
	endtask

	initial begin
		reset = 1'b1;
		req_valid = 1'b0;
		req_op = 2'h0;
		req_block = 12'h000;
		req_page = 5'h00;
		req_data = 8'h00;
		repeat (5) @(negedge clk);
		reset = 1'b0;
		t_scan();
		t_basic();
		t_remap();
		t_fail();
		t_misc();
		finish_test();
	end
endmodule

// ==== design/busy_timer.sv ====
`timescale 1ns/10ps
// waits for the busy line, with a cycle ceiling as watchdog
module busy_timer
	import flash_host_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// control
	input wire logic start,
	input wire logic [24:0] limit,
	input wire logic ready_sync,
	// result
	output logic done,
	output logic timeout
);
	logic [24:0] count_r;
	logic run_r;
	// settle counter: ignore ready for the first few cycles
	always_ff @(posedge clk) begin
		if (reset) begin
			run_r <= 1'b0;
			count_r <= 25'h0;
		end else if (start) begin
			run_r <= 1'b1;
			count_r <= 25'h0;
		end else if (done) begin
			run_r <= 1'b0;
		end else if (run_r) begin
			count_r <= count_r + 25'h1;
		end
	end
	// done once ready is seen after the busy-entry allowance
	assign timeout = run_r && (count_r >= limit);
	assign done = run_r && ((ready_sync && count_r > 25'h10) || timeout);
endmodule

// ==== design/flash_host.sv ====
`timescale 1ns/10ps
module flash_host
	import flash_host_pkg::*;
#(
	// last block the boot scan visits; lowered only to shorten tests
	parameter logic [BLK_W-1:0] SCAN_LAST = LAST_BLOCK
)
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// user request side
	input wire logic req_valid,
	input wire logic [1:0] req_op,
	input wire logic [BLK_W-1:0] req_block,
	input wire logic [4:0] req_page,
	input wire logic [7:0] req_data,
	output logic req_ready,
	output logic [7:0] rsp_data,
	output logic rsp_valid,
	output logic rsp_fail,
	output logic scan_done,
	// flash pins
	output logic cmd_latch,
	output logic addr_latch,
	output logic chip_sel_n,
	output logic write_strobe_n,
	output logic output_strobe_n,
	output logic write_prot_n,
	output logic [7:0] io_out,
	output logic io_oe_n,
	input wire logic [7:0] io_in,
	input wire logic ready_busy
);
	typedef enum logic [3:0] {
		S_IDLE = 4'h0, S_CMD = 4'h1, S_ADDR = 4'h2, S_DATA = 4'h3,
		S_CMD2 = 4'h4, S_WAIT = 4'h5, S_READ = 4'h6, S_STAT = 4'h7,
		S_BREAK = 4'h8, S_DONE = 4'h9
	} state_type;
	state_type state_r;
	// synchronisers for pins
	logic rb_meta_r, rb_r;
	logic [7:0] io_meta_r, io_r;
	// phase counter for strobe pulses
	logic [3:0] ph_r;
	logic [2:0] step_r; // which byte of a cycle group
	logic [7:0] cmd_r, cmd2_r;
	logic [1:0] op_r;
	logic scanning_r; // boot scan in progress
	logic [BLK_W-1:0] blk_r, phys_r;
	logic [1:0] scan_page_r;
	logic bad_seen_r;
	logic [BLOCKS-1:0] bad_r; // invalid-block table
	logic [4:0] page_r;
	logic [7:0] wdata_r;
	logic [24:0] wait_lim;
	logic wait_go, wait_done, wait_to;
	logic spare_r; // current access aims at spare area
	logic main_prog_r [32]; // main area programmed since erase
	logic strobe_end;
	logic [5:0] brk_r; // select-high break counter
	logic brk_done;
	always_ff @(posedge clk) begin
		rb_meta_r <= ready_busy;
		rb_r <= rb_meta_r;
		io_meta_r <= io_in;
		io_r <= io_meta_r;
	end
	// strobe pacing: each bus cycle is 2*STROBE_CYC clocks
	assign strobe_end = (ph_r == 4'(2 * STROBE_CYC - 1));
	always_ff @(posedge clk) begin
		if (reset || state_r == S_IDLE || state_r == S_WAIT ||
		    state_r == S_BREAK)
			ph_r <= 4'h0;
		else if (strobe_end)
			ph_r <= 4'h0;
		else
			ph_r <= ph_r + 4'h1;
	end
	// bad logical block mapped to next physical, good or not; last block kept
	always_comb begin
		phys_r = req_block;
		if (bad_r[req_block] && req_block != LAST_BLOCK)
			phys_r = req_block + 12'h1;
	end
	// watchdog ceiling per operation, using device maxima
	always_comb begin
		case (op_r)
			REQ_PROG: wait_lim = 25'(PROG_CYC + DUMMY_CYC + GUARD_CYC);
			REQ_ERASE: wait_lim = 25'(ERASE_CYC + GUARD_CYC);
			REQ_RESET: wait_lim = 25'(RESET_CYC + GUARD_CYC);
			default: wait_lim = 25'(FETCH_CYC + GUARD_CYC);
		endcase
	end
	// reset has no second command, so its wait starts at once
	assign wait_go = strobe_end && (state_r == S_CMD2 ||
		(state_r == S_CMD && op_r == REQ_RESET) ||
		(state_r == S_ADDR && op_r == REQ_READ && step_r == 3'h3));
	busy_timer u_wait (
		.clk(clk),
		.reset(reset),
		.start(wait_go),
		.limit(wait_lim),
		.ready_sync(rb_r),
		.done(wait_done),
		.timeout(wait_to)
	);
	// main sequencer
	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= S_IDLE;
			step_r <= 3'h0;
			cmd_r <= CMD_RESET;
			cmd2_r <= CMD_RESET;
			op_r <= REQ_RESET;
			scanning_r <= 1'b1;
			blk_r <= '0;
			scan_page_r <= 2'h0;
			bad_seen_r <= 1'b0;
			page_r <= 5'h0;
			wdata_r <= 8'h0;
			spare_r <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_fail <= 1'b0;
			rsp_data <= 8'h0;
			bad_r <= '0;
		end else begin
			rsp_valid <= 1'b0;
			case (state_r)
				S_IDLE: begin
					step_r <= 3'h0;
					if (scanning_r) begin
						op_r <= REQ_READ;
						cmd_r <= CMD_READ_C;
						spare_r <= 1'b1;
						page_r <= {3'h0, scan_page_r};
						state_r <= S_CMD;
					end else if (req_valid) begin
						op_r <= req_op;
						blk_r <= phys_r;
						page_r <= req_page;
						wdata_r <= req_data;
						spare_r <= 1'b0;
						state_r <= S_CMD;
						case (req_op)
							REQ_PROG: cmd_r <= CMD_PROG1;
							REQ_ERASE: cmd_r <= CMD_ERASE1;
							REQ_RESET: cmd_r <= CMD_RESET;
							default: cmd_r <= CMD_READ_A;
						endcase
						cmd2_r <= (req_op == REQ_ERASE) ? CMD_ERASE2 :
							CMD_PROG2;
						if (req_op == REQ_PROG && main_prog_r[req_page]) begin
							rsp_fail <= 1'b1;
							rsp_valid <= 1'b1;
							state_r <= S_IDLE;
						end
					end
				end
				S_CMD: if (strobe_end) begin
					// a second reset code while busy could stretch busy
					if (op_r == REQ_RESET)
						state_r <= S_WAIT;
					else
						state_r <= S_ADDR;
				end
				S_ADDR: if (strobe_end) begin
					step_r <= step_r + 3'h1;
					if (op_r == REQ_ERASE && step_r == 3'h2) begin
						step_r <= 3'h0;
						state_r <= S_CMD2;
					end else if (step_r == 3'h3) begin
						step_r <= 3'h0;
						state_r <= (op_r == REQ_PROG) ? S_DATA : S_WAIT;
					end
				end
				S_DATA: if (strobe_end) state_r <= S_CMD2;
				S_CMD2: if (strobe_end) state_r <= S_WAIT;
				S_WAIT: if (wait_done) begin
					if (op_r == REQ_READ) state_r <= S_READ;
					else if (op_r == REQ_RESET) state_r <= S_DONE;
					else begin
						cmd_r <= CMD_STATUS;
						state_r <= S_STAT;
					end
				end
				S_READ: if (strobe_end) begin
					// single serial read then select high
					rsp_data <= io_r;
					if (scanning_r && io_r != ERASED)
						bad_seen_r <= 1'b1;
					state_r <= S_BREAK;
				end
				S_STAT: if (strobe_end && step_r == 3'h1) begin
					rsp_fail <= io_r[0];
					if (io_r[0] && blk_r != SAFE_BLOCK)
						bad_r[blk_r] <= 1'b1;
					state_r <= S_DONE;
				end else if (strobe_end) step_r <= 3'h1;
				S_BREAK: if (ph_r == 4'h0 && brk_done) begin
					state_r <= S_DONE;
				end
				S_DONE: begin
					if (scanning_r) begin
						if (scan_page_r == PAGES_CHECKED - 2'h1) begin
							// marker check on page 0 or 1
							if (bad_seen_r && blk_r != SAFE_BLOCK)
								bad_r[blk_r] <= 1'b1;
							bad_seen_r <= 1'b0;
							scan_page_r <= 2'h0;
							blk_r <= blk_r + 12'h1;
							if (blk_r == SCAN_LAST) scanning_r <= 1'b0;
						end else
							scan_page_r <= scan_page_r + 2'h1;
					end else begin
						rsp_valid <= 1'b1;
						if (op_r == REQ_PROG || op_r == REQ_READ)
							rsp_fail <= (op_r == REQ_PROG) && rsp_fail;
						else if (op_r == REQ_RESET)
							rsp_fail <= 1'b0;
					end
					state_r <= S_IDLE;
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end
	// select-high break timer; the total needs six bits
	assign brk_done = (brk_r >= 6'(BREAK_CYC + READY_CYC));
	always_ff @(posedge clk) begin
		if (reset || state_r != S_BREAK)
			brk_r <= 6'h0;
		else if (!brk_done)
			brk_r <= brk_r + 6'h1;
	end
	always_ff @(posedge clk) begin
		for (int i = 0; i < 32; i++) begin
			if (reset || (state_r == S_CMD2 && op_r == REQ_ERASE)) begin
				main_prog_r[i] <= 1'b0;
			end else if (state_r == S_CMD2 && op_r == REQ_PROG &&
			    strobe_end && page_r == 5'(i)) begin
				main_prog_r[i] <= 1'b1;
			end
		end
	end
	// pin drive, strobes low during first half of each bus cycle
	always_comb begin
		cmd_latch = (state_r == S_CMD || state_r == S_CMD2 ||
			(state_r == S_STAT && step_r == 3'h0));
		addr_latch = (state_r == S_ADDR);
		chip_sel_n = (state_r == S_IDLE || state_r == S_BREAK ||
			state_r == S_DONE);
		write_prot_n = 1'b1;
		write_strobe_n = 1'b1;
		output_strobe_n = 1'b1;
		io_oe_n = 1'b1;
		io_out = 8'h0;
		if (state_r == S_CMD || (state_r == S_STAT && step_r == 3'h0)) begin
			io_out = cmd_r;
		end else if (state_r == S_CMD2) begin
			io_out = cmd2_r;
		end else if (state_r == S_ADDR) begin
			case (op_r == REQ_ERASE ? step_r + 3'h1 : step_r)
				// byte-wide marker only, no word bus
				3'h0: io_out = spare_r ? MARK_COL : 8'h0;
				3'h1: io_out = {blk_r[2:0], page_r};
				3'h2: io_out = blk_r[10:3];
				default: io_out = {7'h0, blk_r[11]};
			endcase
		end else if (state_r == S_DATA) begin
			io_out = wdata_r;
		end
		if (state_r inside {S_CMD, S_CMD2, S_ADDR, S_DATA} ||
		    (state_r == S_STAT && step_r == 3'h0)) begin
			io_oe_n = 1'b0;
			write_strobe_n = (ph_r >= 4'(STROBE_CYC));
		end
		if (state_r == S_READ || (state_r == S_STAT && step_r == 3'h1))
			output_strobe_n = (ph_r >= 4'(STROBE_CYC));
	end
	assign req_ready = (state_r == S_IDLE) && !scanning_r;
	assign scan_done = !scanning_r;
	// good blocks never steered to a bad one
	a_map_avoids_bad: assert property (@(posedge clk) disable iff (reset)
		(state_r == S_IDLE && req_valid && req_ready && !bad_r[req_block])
		|-> phys_r == req_block)
		else $error("good block remapped");
	// no erase command before scan completes
	a_scan_before_erase: assert property (@(posedge clk) disable iff (reset)
		(state_r == S_CMD && cmd_r == CMD_ERASE1) |-> !scanning_r)
		else $error("erase during scan");
	// select held high after serial read
	a_select_break: assert property (@(posedge clk) disable iff (reset)
		$rose(state_r == S_BREAK) |-> chip_sel_n [*8])
		else $error("select break too short");
	// no second main program of a page
	a_main_once: assert property (@(posedge clk) disable iff (reset)
		(state_r == S_CMD2 && op_r == REQ_PROG) |-> !main_prog_r[page_r]
		|| ph_r != 4'h0)
		else $error("page programmed twice");
	// failed status marks block bad next cycle
	a_retire_fail: assert property (@(posedge clk) disable iff (reset)
		(state_r == S_STAT && strobe_end && step_r == 3'h1 && io_r[0]
		&& blk_r != SAFE_BLOCK) |=> bad_r[$past(blk_r)])
		else $error("failed block not retired");
	a_block_zero: assert property (@(posedge clk) disable iff (reset)
		!bad_r[0])
		else $error("block zero marked bad");
endmodule

// ==== design/flash_host_pkg.sv ====
package flash_host_pkg;
	// clock and timing figures
	localparam int CLK_NS = 10;
	localparam int FETCH_MAX_US = 12;
	localparam int PROG_MAX_US = 500;
	localparam int ERASE_MAX_MS = 3;
	localparam int RESET_MAX_US = 5;
	localparam int DUMMY_MAX_US = 10;
	localparam int BREAK_MIN_NS = 100;
	localparam int SEL_READY_NS = 50;
	localparam int RISE_ALLOW_NS = 200;
	localparam int STROBE_NS = 30;
	// derived cycle counts (maxima round down, minima round up)
	localparam int FETCH_CYC = FETCH_MAX_US * 1000 / CLK_NS;
	localparam int PROG_CYC = PROG_MAX_US * 1000 / CLK_NS;
	localparam int ERASE_CYC = ERASE_MAX_MS * 1000000 / CLK_NS;
	localparam int RESET_CYC = RESET_MAX_US * 1000 / CLK_NS;
	localparam int DUMMY_CYC = DUMMY_MAX_US * 1000 / CLK_NS;
	localparam int BREAK_CYC = (BREAK_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int READY_CYC = (SEL_READY_NS + RISE_ALLOW_NS) / CLK_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	// busy-line guard margin beyond documented max
	localparam int GUARD_CYC = 16;
	// command codes
	localparam logic [7:0] CMD_READ_A = 8'h00;
	localparam logic [7:0] CMD_READ_C = 8'h50;
	localparam logic [7:0] CMD_ERASE1 = 8'h60;
	localparam logic [7:0] CMD_ERASE2 = 8'hd0;
	localparam logic [7:0] CMD_PROG1 = 8'h80;
	localparam logic [7:0] CMD_PROG2 = 8'h10;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_RESET = 8'hff;
	localparam logic [7:0] ERASED = 8'hff;
	// geometry and marker position
	localparam int BLOCKS = 4096;
	localparam int BLK_W = 12;
	localparam logic [7:0] MARK_COL = 8'h05; // 517 - 512 in spare area
	localparam logic [7:0] SPARE_MAX = 8'h0f; // spare is 16 bytes
	localparam logic [1:0] PAGES_CHECKED = 2'h2;
	localparam logic [BLK_W-1:0] LAST_BLOCK = 12'hfff;
	localparam logic [BLK_W-1:0] SAFE_BLOCK = 12'h000;
	// host request codes
	localparam logic [1:0] REQ_READ = 2'h0;
	localparam logic [1:0] REQ_PROG = 2'h1;
	localparam logic [1:0] REQ_ERASE = 2'h2;
	localparam logic [1:0] REQ_RESET = 2'h3;
endpackage
